/* File: hw/rbe_filter.sv */
// Two-flop synchroniser followed by a stable-count debounce filter.
// Assumes one clock; output changes only after the input holds still.
`timescale 1ns/1ps
module rbe_filter #(
  parameter int   COUNT     = 100,
  parameter logic INIT      = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic raw_i,
  output logic      level_o
);
  localparam int CW = (COUNT < 2) ? 1 : $clog2(COUNT + 1);

  initial begin
    if (COUNT < 1) $error("rbe_filter: COUNT must be at least 1");
  end

  logic          meta_reg;
  logic          sync_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= raw_i;
      sync_reg <= meta_reg;
    end
  end

  // Count cycles of disagreement; accept the new level after COUNT
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      level_o <= INIT;
    end else if (sync_reg == level_o) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(COUNT - 1)) begin
      cnt_reg <= '0;
      level_o <= sync_reg;
    end else begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end
endmodule

/* File: hw/rbe_pkg.sv */
// Package for the reset and boot-load entry block: timing and switch layout.
// Assumes a 100 MHz clock; users write every reference with rbe_pkg::.
package rbe_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  // Debounce settle time and minimum reset pulse, in microseconds
  localparam int          DEBOUNCE_US     = 1;
  localparam int          RESET_HOLD_US   = 2;
  localparam int          DEBOUNCE_CYC    = (DEBOUNCE_US * 1000)
                                            / CLK_PERIOD_NS;
  localparam int          RESET_HOLD_CYC  = (RESET_HOLD_US * 1000
                                             + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  // Positions in the eight-bit configuration switch bank (switch n at n-1)
  localparam int          CFG_WIDTH       = 8;
  localparam int          CFG_DTR_RST_BIT = 6;
  localparam int          CFG_RTS_LD_BIT  = 7;
  // Synchronised input levels seen at reset release
  // Request-to-send idles high, so its filter starts high: no false edge
  localparam logic [3:0]  INPUTS_RESET    = 4'h8;
  // Line indices into the filtered input vector
  localparam int          IDX_RESET_PB    = 0;
  localparam int          IDX_LOAD_PB     = 1;
  localparam int          IDX_DTR         = 2;
  localparam int          IDX_RTS         = 3;

  typedef enum logic [1:0] {
    RBE_RUN   = 2'b00,
    RBE_HOLD  = 2'b01,
    RBE_DRAIN = 2'b11
  } rbe_state_t;
endpackage

/* File: hw/rbe_reset_entry.sv */
// Reset and boot-mode entry for a microcontroller with an on-chip serial
// loader: pushbuttons and host handshake lines drive the MCU reset and
// program-fetch strobe; second port handshakes are looped back.
// Assumes all inputs synchronous-capable, single 100 MHz clock, and that
// reset_i is separate from the reset this block drives toward the MCU.
//
// Summary of operation
// R01 - Holding reset button drives MCU reset high; release gives normal boot.
// R02 - Holding load button drives reset high and fetch strobe low.
// R03 - Load mode runs ROM loader; host sends carriage return first.
// R04 - Rising terminal-ready edge from host resets MCU into normal run.
// R05 - Falling request-to-send edge from host resets MCU into load mode.
// R06 - Without handshakes board runs; host reset and loading unavailable.
// R07 - Second port loops terminal-ready to set-ready, request to clear.
// R08 - Second port passes only transmit and receive data.
// R09 - Reset button recovers a hung board to normal operation.
// R10 - Terminal-ready reset only when its configuration switch enables it.
// R11 - Request-to-send load reset only when its switch enables it.
// R12 - Inputs synchronised, debounced; reset held a minimum cycle count.
`timescale 1ns/1ps
module rbe_reset_entry #(
  parameter int DEBOUNCE_CYC   = rbe_pkg::DEBOUNCE_CYC,
  parameter int RESET_HOLD_CYC = rbe_pkg::RESET_HOLD_CYC
) (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         reset_pushbutton_n_i,
  input  wire logic                         load_pushbutton_n_i,
  input  wire logic [rbe_pkg::CFG_WIDTH-1:0] config_switch_bank_i,
  input  wire logic                         port0_dtr_i,
  input  wire logic                         port0_rts_i,
  input  wire logic                         port0_txd_i,
  output logic                              port0_rxd_o,
  output logic                              port0_dcd_o,
  output logic                              port0_dsr_o,
  output logic                              port0_cts_o,
  output logic                              port0_ri_o,
  input  wire logic                         port1_dtr_i,
  input  wire logic                         port1_rts_i,
  input  wire logic                         port1_txd_i,
  output logic                              port1_rxd_o,
  output logic                              port1_dcd_o,
  output logic                              port1_dsr_o,
  output logic                              port1_cts_o,
  output logic                              port1_ri_o,
  input  wire logic                         mcu_txd0_i,
  output logic                              mcu_rxd0_o,
  input  wire logic                         mcu_txd1_i,
  output logic                              mcu_rxd1_o,
  output logic                              mcu_reset_o,
  output logic                              program_fetch_strobe_n_o,
  output logic                              serial_load_request_o
);
  localparam int HW = (RESET_HOLD_CYC < 2) ? 1 : $clog2(RESET_HOLD_CYC + 1);

  initial begin
    if (DEBOUNCE_CYC < 1) $error("DEBOUNCE_CYC must be at least 1");
    if (RESET_HOLD_CYC < 1) $error("RESET_HOLD_CYC must be at least 1");
  end

  // Active-high raw requests: buttons pressed, host lines at logic level
  logic [3:0] raw;
  logic [3:0] filt;
  logic [3:0] filt_prev_reg;

  assign raw[rbe_pkg::IDX_RESET_PB] = ~reset_pushbutton_n_i;
  assign raw[rbe_pkg::IDX_LOAD_PB]  = ~load_pushbutton_n_i;
  assign raw[rbe_pkg::IDX_DTR]      = port0_dtr_i;
  assign raw[rbe_pkg::IDX_RTS]      = port0_rts_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      rbe_filter #(
        .COUNT (DEBOUNCE_CYC),
        .INIT  (rbe_pkg::INPUTS_RESET[g])
      ) u_filt (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .raw_i   (raw[g]),
        .level_o (filt[g])
      ); // [R12]
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      filt_prev_reg <= rbe_pkg::INPUTS_RESET;
    end else begin
      filt_prev_reg <= filt;
    end
  end

  logic rst_btn;
  logic ld_btn;
  logic dtr_rise;
  logic rts_fall;
  logic host_rst;
  logic host_ld;

  assign rst_btn  = filt[rbe_pkg::IDX_RESET_PB];
  assign ld_btn   = filt[rbe_pkg::IDX_LOAD_PB];
  assign dtr_rise = filt[rbe_pkg::IDX_DTR]
                    & ~filt_prev_reg[rbe_pkg::IDX_DTR]; // [R04]
  assign rts_fall = ~filt[rbe_pkg::IDX_RTS]
                    & filt_prev_reg[rbe_pkg::IDX_RTS]; // [R05]
  assign host_rst = dtr_rise
                    & config_switch_bank_i[rbe_pkg::CFG_DTR_RST_BIT]; // [R10]
  assign host_ld  = rts_fall
                    & config_switch_bank_i[rbe_pkg::CFG_RTS_LD_BIT]; // [R11]


  // Reset pulse sequencing
  logic                req_any;
  logic                req_load;
  logic                req_norm;
  logic                hold_done;
  logic                load_next;
  logic                load_reg;
  logic [HW-1:0]       hold_cnt_reg;
  rbe_pkg::rbe_state_t state_reg;
  rbe_pkg::rbe_state_t state_next;

  // True while the MCU reset line must be driven high
  function automatic logic in_reset(input rbe_pkg::rbe_state_t s);
    return (s == rbe_pkg::RBE_HOLD);
  endfunction

  // True while the boot mode must still be presented to the MCU
  function automatic logic in_boot(input rbe_pkg::rbe_state_t s);
    return (s != rbe_pkg::RBE_RUN);
  endfunction

  // Idle host lines give no edges, so only the buttons act then
  assign req_load  = ld_btn | host_ld; // [R02] [R05] [R06]
  assign req_norm  = rst_btn | host_rst; // [R01] [R04] [R09]
  assign req_any   = req_load | req_norm;
  assign hold_done = (hold_cnt_reg == HW'(RESET_HOLD_CYC - 1)); // [R12]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rbe_pkg::RBE_RUN: begin
        if (req_any) begin
          state_next = rbe_pkg::RBE_HOLD;
        end
      end
      rbe_pkg::RBE_HOLD: begin
        // Held buttons keep restarting the count
        if (hold_done && !req_any) begin
          state_next = rbe_pkg::RBE_DRAIN; // [R01] [R09]
        end
      end
      rbe_pkg::RBE_DRAIN: begin
        if (req_any) begin
          state_next = rbe_pkg::RBE_HOLD;
        end else begin
          state_next = rbe_pkg::RBE_RUN;
        end
      end
      default: begin
        state_next = rbe_pkg::RBE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= rbe_pkg::RBE_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Minimum pulse counter, restarted by every new request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold_cnt_reg <= '0;
    end else if (req_any || (state_next != rbe_pkg::RBE_HOLD)) begin
      hold_cnt_reg <= '0;
    end else if (!hold_done) begin
      hold_cnt_reg <= hold_cnt_reg + HW'(1); // [R12]
    end
  end

  // Boot mode choice; a load request wins over a normal one
  always_comb begin
    load_next = load_reg;
    if (req_norm) begin
      load_next = 1'b0; // [R01] [R04]
    end
    if (req_load) begin
      load_next = 1'b1; // [R02] [R05]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      load_reg <= 1'b0;
    end else begin
      load_reg <= load_next;
    end
  end

  // Loader stays selected until the next normal reset
  assign serial_load_request_o = load_reg; // [R03]

  // Strobe stays low one cycle past reset release so it is sampled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mcu_reset_o              <= 1'b0;
      program_fetch_strobe_n_o <= 1'b1;
    end else begin
      mcu_reset_o              <= in_reset(state_next); // [R01] [R02]
      program_fetch_strobe_n_o <= ~(load_next
                                    & in_boot(state_next)); // [R02] [R05]
    end
  end

  // Serial data lines, idle at mark
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mcu_rxd0_o  <= 1'b1;
      port0_rxd_o <= 1'b1;
    end else begin
      mcu_rxd0_o  <= port0_txd_i; // [R06]
      port0_rxd_o <= mcu_txd0_i; // [R06]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mcu_rxd1_o  <= 1'b1;
      port1_rxd_o <= 1'b1;
    end else begin
      mcu_rxd1_o  <= port1_txd_i; // [R08]
      port1_rxd_o <= mcu_txd1_i; // [R08]
    end
  end

  // Second port handshakes are plain wires and never touch reset
  assign port1_dsr_o = port1_dtr_i; // [R07]
  assign port1_cts_o = port1_rts_i; // [R07]

  // Status lines without function
  assign port0_dcd_o = 1'b0;
  assign port0_dsr_o = 1'b0;
  assign port0_cts_o = 1'b0;
  assign port0_ri_o  = 1'b0;
  assign port1_dcd_o = 1'b0; // [R08]
  assign port1_ri_o  = 1'b0; // [R08]
endmodule

/* File: sim/rbe_checker.sv */
// Checker on the reset entry block ports.
// Assumes debounce of 3 and reset hold of 8 cycles.
`timescale 1ns/1ps
module rbe_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       reset_pushbutton_n_i,
  input wire logic       load_pushbutton_n_i,
  input wire logic [7:0] config_switch_bank_i,
  input wire logic       port0_dtr_i,
  input wire logic       port0_rts_i,
  input wire logic       port1_dtr_i,
  input wire logic       port1_rts_i,
  input logic            port1_dsr_o,
  input logic            port1_cts_o,
  input logic            mcu_reset_o,
  input logic            program_fetch_strobe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_loop_dsr: assert property (port1_dsr_o == port1_dtr_i)
    else $error("set-ready loop broken");
  chk_loop_cts: assert property (port1_cts_o == port1_rts_i)
    else $error("clear-to-send loop broken");
  chk_hold_min: assert property (
    $rose(mcu_reset_o) |-> mcu_reset_o[*8])
    else $error("reset pulse too short");
  chk_btn_reset: assert property (
    (!reset_pushbutton_n_i)[*8] |-> ##2 mcu_reset_o)
    else $error("button reset missing");
  chk_load_strobe: assert property (
    (!load_pushbutton_n_i)[*8] |->
    ##2 (mcu_reset_o && !program_fetch_strobe_n_o))
    else $error("load hold bad");
  chk_dtr_edge: assert property (
    config_switch_bank_i[6] && $rose(port0_dtr_i)
    |-> ##[1:14] mcu_reset_o) else $error("host reset missing");
  chk_rts_load: assert property (
    config_switch_bank_i[7] && $fell(port0_rts_i)
    |-> ##[1:14] (mcu_reset_o && !program_fetch_strobe_n_o))
    else $error("no load");
  chk_gate_quiet: assert property (
    config_switch_bank_i[7:6] == 2'h0 && reset_pushbutton_n_i
    && load_pushbutton_n_i && !mcu_reset_o |=> !mcu_reset_o)
    else $error("reset while host lines disabled");
endmodule
bind rbe_reset_entry rbe_checker i_rbe_checker (
  .clk_i(clk_i), .reset_i(reset_i),
  .reset_pushbutton_n_i(reset_pushbutton_n_i), .port1_dtr_i(port1_dtr_i),
  .load_pushbutton_n_i(load_pushbutton_n_i), .port1_rts_i(port1_rts_i),
  .config_switch_bank_i(config_switch_bank_i), .port0_dtr_i(port0_dtr_i),
  .port0_rts_i(port0_rts_i), .port1_dsr_o(port1_dsr_o),
  .port1_cts_o(port1_cts_o), .mcu_reset_o(mcu_reset_o),
  .program_fetch_strobe_n_o(program_fetch_strobe_n_o));

/* File: sim/rbe_host_model.sv */
// Host model: drives the first port's handshake and data lines.
// Assumes requests arrive from the bench on the rising clock edge.
`timescale 1ns/1ps
module rbe_host_model (
  input  wire logic clk_i,
  input  wire logic dtr_req_i,
  input  wire logic rts_req_i,
  output logic      dtr_o,
  output logic      rts_o,
  output logic      txd_o
);
  always_ff @(posedge clk_i) dtr_o <= dtr_req_i;
  always_ff @(posedge clk_i) rts_o <= ~rts_req_i;
  // Line idles at mark, no frame sent
  assign txd_o = 1'h1;
endmodule

/* File: sim/tb_top.sv */
// Testbench for the reset entry block with a host handshake model.
// Assumes short debounce and hold counts set at the instance.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, reset_i = 1, rst_n = 1, ld_n = 1, d1 = 0, r1 = 0;
  logic dreq = 0, rreq = 0, dtr, rts, txd, mrst, fs_n, dsr1, cts1, slr;
  logic [7:0] cfg = 8'h00;
  int num_errors = 0, checks_done = 0;
  initial forever #5 clk_i = ~clk_i;
  rbe_host_model i_rbe_host_model (.clk_i(clk_i), .dtr_req_i(dreq),
    .rts_req_i(rreq), .dtr_o(dtr), .rts_o(rts), .txd_o(txd));
  rbe_reset_entry #(.DEBOUNCE_CYC(3), .RESET_HOLD_CYC(8)) i_rbe_reset_entry (
    .clk_i(clk_i), .reset_i(reset_i), .reset_pushbutton_n_i(rst_n),
    .load_pushbutton_n_i(ld_n), .config_switch_bank_i(cfg), .port0_dtr_i(dtr),
    .port0_rts_i(rts), .port0_txd_i(txd), .port0_rxd_o(), .port0_dcd_o(),
    .port0_dsr_o(), .port0_cts_o(), .port0_ri_o(), .port1_dtr_i(d1),
    .port1_rts_i(r1), .port1_txd_i(1'h1), .port1_rxd_o(), .port1_dcd_o(),
    .port1_dsr_o(dsr1), .port1_cts_o(cts1), .port1_ri_o(), .mcu_txd0_i(1'h1),
    .mcu_rxd0_o(), .mcu_txd1_i(1'h1), .mcu_rxd1_o(), .mcu_reset_o(mrst),
    .program_fetch_strobe_n_o(fs_n), .serial_load_request_o(slr));
  task automatic chk(input logic s, input logic e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_buttons;
    rst_n <= 1'h0;
    wt(14);
    chk(mrst, 1'h1);
    rst_n <= 1'h1;
    wt(30);
    chk(mrst, 1'h0);
    chk(slr, 1'h0);
    ld_n <= 1'h0;
    wt(14);
    chk(mrst, 1'h1);
    chk(fs_n, 1'h0);
    ld_n <= 1'h1;
    wt(30);
    chk(mrst, 1'h0);
    chk(slr, 1'h1);
    $display("buttons done");
  endtask
  task automatic t_host(input logic [7:0] sw, input logic e);
    cfg <= sw;
    dreq <= 1'h0;
    rreq <= 1'h0;
    wt(30);
    dreq <= 1'h1;
    wt(12);
    chk(mrst, e);
    chk(slr, ~e);
    wt(30);
    rreq <= 1'h1;
    wt(12);
    chk(mrst, e);
    chk(fs_n, ~e);
    chk(slr, 1'h1);
    wt(30);
    chk(mrst, 1'h0);
    $display("host lines done");
  endtask
  task automatic t_loop;
    for (int i = 0; i < 4; i++) begin
      d1 <= i[0];
      r1 <= i[1];
      wt(2);
      chk(dsr1, i[0]);
      chk(cts1, i[1]);
    end
    $display("loopback done");
  endtask
  initial begin
    wt(5000);
    num_errors++;
    results;
  end
  initial begin
    wt(10);
    reset_i <= 1'h0;
    wt(20);
    t_buttons;
    t_host(8'hc0, 1'h1);
    t_host(8'h00, 1'h0);
    t_loop;
    results;
  end
endmodule
